// >>> hrs_params.svh
// Offsets, field positions, reset values and sizes of the return stack
`ifndef HRS_PARAMS_SVH
`define HRS_PARAMS_SVH

`define HRS_DEPTH          16
`define HRS_PC_W           15
`define HRS_PTR_W          5
`define HRS_IDX_W          4
`define HRS_ADDR_W         3
`define HRS_DATA_W         8
`define HRS_HIGH_W         7

`define HRS_PTR_RESET      5'h1F
`define HRS_PTR_FULL       5'h0F
`define HRS_PTR_ONE        5'h01
`define HRS_CFG_RESET      1'h0

`define HRS_OFS_TOP_LOW    3'h0
`define HRS_OFS_TOP_HIGH   3'h1
`define HRS_OFS_INDEX      3'h2
`define HRS_OFS_CONFIG     3'h3
`define HRS_OFS_STATUS     3'h4
`define HRS_OFS_INT_CLEAR  3'h5
`define HRS_OFS_INT_ENABLE 3'h6

`define HRS_BIT_OVF        0
`define HRS_BIT_UNF        1
`define HRS_BIT_FRE        0
`define HRS_EVT_W          2

`endif

// >>> hrs_pkg.sv
// Types shared by the return stack modules
`include "hrs_params.svh"

package hrs_pkg;

    typedef logic [`HRS_PC_W-1:0]   hrs_pc_t;
    typedef logic [`HRS_PTR_W-1:0]  hrs_ptr_t;
    typedef logic [`HRS_IDX_W-1:0]  hrs_idx_t;
    typedef logic [`HRS_DATA_W-1:0] hrs_byte_t;
    typedef logic [`HRS_EVT_W-1:0]  hrs_evt_t;

    typedef enum logic [1:0] {HRS_OP_IDLE, HRS_OP_PUSH, HRS_OP_POP} hrs_op_e;

    // Request from the core sequencer
    typedef struct packed {
        logic    push;
        logic    pop;
        hrs_pc_t pc;
    } hrs_core_req_s;

    // Answer to the core sequencer
    typedef struct packed {
        logic    popValid;
        hrs_pc_t popPc;
        logic    faultReset;
    } hrs_core_rsp_s;

    // Plain register port from software
    typedef struct packed {
        logic [`HRS_ADDR_W-1:0] addr;
        hrs_byte_t              wrData;
        logic                   wr;
        logic                   rd;
    } hrs_reg_req_s;

    typedef struct packed {
        hrs_pc_t [`HRS_DEPTH-1:0] entry;
    } hrs_mem_s;

    typedef struct packed {
        hrs_evt_t status;
        hrs_evt_t enable;
        logic     irq;
    } hrs_irq_s;

    typedef struct packed {
        hrs_ptr_t      ptr;
        logic          faultResetEnable;
        hrs_core_rsp_s rsp;
        hrs_byte_t     rdData;
        hrs_op_e       lastOp;
    } hrs_top_s;

endpackage : hrs_pkg

// >>> hrs_stack_mem.sv
// Sixteen by fifteen bit stack storage in flip-flops
`timescale 1ns/1ps
`include "hrs_params.svh"

module hrs_stack_mem
    import hrs_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     reset,
    input  wire hrs_idx_t wrIndex,
    input  wire logic     wrLow,
    input  wire logic     wrHigh,
    input  wire hrs_pc_t  wrData,
    input  wire hrs_idx_t rdIndex,
    output hrs_pc_t       rdData
);

    hrs_mem_s state;
    hrs_mem_s next_state;
    logic [`HRS_DEPTH-1:0] hit;

    // One select line per entry
    genvar gi;
    generate
        for (gi = 0; gi < `HRS_DEPTH; gi++)
        begin : g_hit
            assign hit[gi] = (wrIndex == hrs_idx_t'(gi));
        end
    endgenerate

    // Byte lanes let software patch one half of an entry
    always_comb
    begin
        next_state = state;
        for (int i = 0; i < `HRS_DEPTH; i++)
        begin
            if (hit[i] && wrLow)
            begin
                next_state.entry[i][`HRS_DATA_W-1:0] =
                    wrData[`HRS_DATA_W-1:0];
            end
            if (hit[i] && wrHigh)
            begin
                next_state.entry[i][`HRS_PC_W-1:`HRS_DATA_W] =
                    wrData[`HRS_PC_W-1:`HRS_DATA_W];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Combinational read; the top registers what it uses
    assign rdData = state.entry[rdIndex];

endmodule : hrs_stack_mem

// >>> hrs_irq.sv
// Sticky stack fault status with enable mask and level interrupt
`timescale 1ns/1ps
`include "hrs_params.svh"

module hrs_irq
    import hrs_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     reset,
    input  wire hrs_evt_t eventIn,
    input  wire hrs_evt_t clearMask,
    input  wire logic     enableWr,
    input  wire hrs_evt_t enableData,
    output hrs_evt_t      status,
    output hrs_evt_t      enable,
    output logic          irq
);

    hrs_irq_s state;
    hrs_irq_s next_state;

    // A new event beats a clear arriving in the same cycle
    always_comb
    begin
        next_state = state;
        next_state.status = (state.status & ~clearMask) | eventIn;
        if (enableWr)
        begin
            next_state.enable = enableData;
        end
        next_state.irq = |(next_state.status & next_state.enable);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign status = state.status;
    assign enable = state.enable;
    assign irq    = state.irq;

endmodule : hrs_irq

// >>> hrs_return_stack.sv
// Hardware return-address stack with software access and fault handling
`timescale 1ns/1ps
`include "hrs_params.svh"

// Behaviour
// - The stack holds sixteen fifteen-bit entries apart from any memory.
// - Calls, calls via working register and interrupt vectoring push PC.
// - Returns, returns with literal and interrupt returns pop the stack.
// - Pushes and pops never touch the PC upper latch.
// - With fault reset off the stack wraps, push 17 overwrites entry 0.
// - Overflow and underflow flags are set whatever the fault reset mode.
// - Software reads and writes the index and the top pair of the stack.
// - Writing the index moves the top pair onto the chosen entry.
// - The index is five bits so overflow and underflow can be seen.
// - A push bumps the index then writes; a pop reads then drops it.
// - The index points at the newest occupied entry, not a free one.
// - After reset the stack is empty with the index at 0x1F.
// - With fault reset on and the stack empty the top pair reads zero.
module hrs_return_stack
    import hrs_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire hrs_core_req_s coreReq,
    output hrs_core_rsp_s      coreRsp,
    input  wire hrs_reg_req_s  regReq,
    output hrs_byte_t          regRdData,
    output logic               stackIrq
);

    hrs_top_s state;
    hrs_top_s next_state;

    hrs_pc_t  memRd;
    hrs_idx_t memWrIndex;
    logic     memWrLow;
    logic     memWrHigh;
    hrs_pc_t  memWrData;
    hrs_pc_t  topValue;
    logic     emptyZero;
    hrs_ptr_t ptrUp;
    hrs_ptr_t ptrDown;
    hrs_evt_t faultEvt;
    hrs_evt_t clearMask;
    logic     enableWr;
    hrs_evt_t irqStatus;
    hrs_evt_t irqEnable;
    logic     swIdle;
    logic     regWrHit;

    // Storage lives outside data and program space
    hrs_stack_mem u_mem (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wrIndex (memWrIndex),
        .wrLow   (memWrLow),
        .wrHigh  (memWrHigh),
        .wrData  (memWrData),
        .rdIndex (state.ptr[`HRS_IDX_W-1:0]),
        .rdData  (memRd)
    );

    hrs_irq u_irq (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .eventIn    (faultEvt),
        .clearMask  (clearMask),
        .enableWr   (enableWr),
        .enableData (regReq.wrData[`HRS_EVT_W-1:0]),
        .status     (irqStatus),
        .enable     (irqEnable),
        .irq        (stackIrq)
    );

    // Pointer arithmetic wraps naturally in five bits
    assign ptrUp   = state.ptr + `HRS_PTR_ONE;
    assign ptrDown = state.ptr - `HRS_PTR_ONE;

    // Empty in fault reset mode hides stale contents
    assign emptyZero = state.faultResetEnable &&
                       (state.ptr == `HRS_PTR_RESET);
    assign topValue  = emptyZero ? '0 : memRd;

    // The core always wins; a software write to the stack side is dropped in a busy cycle
    assign swIdle   = !coreReq.push && !coreReq.pop;
    assign regWrHit = regReq.wr && swIdle;

    // Fault events feed the sticky flags in both modes
    always_comb
    begin
        faultEvt = '0;
        faultEvt[`HRS_BIT_OVF] = coreReq.push &&
            (state.ptr == `HRS_PTR_FULL);
        faultEvt[`HRS_BIT_UNF] = !coreReq.push && coreReq.pop &&
            (state.ptr == `HRS_PTR_RESET);
    end

    // Interrupt side registers take effect whatever the core does
    always_comb
    begin
        clearMask = '0;
        enableWr  = 1'b0;
        if (regReq.wr && regReq.addr == `HRS_OFS_INT_CLEAR)
        begin
            clearMask = regReq.wrData[`HRS_EVT_W-1:0];
        end
        if (regReq.wr && regReq.addr == `HRS_OFS_INT_ENABLE)
        begin
            enableWr = 1'b1;
        end
    end

    // Stack operation, software access and read data in one place.
    // No output here reaches the PC upper latch; it stays with the core.
    always_comb
    begin
        next_state = state;
        next_state.rsp.popValid   = 1'b0;
        next_state.rsp.faultReset = 1'b0;
        next_state.rdData         = '0;
        next_state.lastOp         = HRS_OP_IDLE;
        memWrIndex = state.ptr[`HRS_IDX_W-1:0];
        memWrLow   = 1'b0;
        memWrHigh  = 1'b0;
        memWrData  = coreReq.pc;

        if (coreReq.push)
        begin
            // Bump first, then store at the new top
            next_state.ptr    = ptrUp;
            next_state.lastOp = HRS_OP_PUSH;
            memWrIndex = ptrUp[`HRS_IDX_W-1:0];
            memWrLow   = 1'b1;
            memWrHigh  = 1'b1;
            if (faultEvt[`HRS_BIT_OVF] && state.faultResetEnable)
            begin
                // Nothing is stored; the device is about to restart
                memWrLow  = 1'b0;
                memWrHigh = 1'b0;
                next_state.ptr = `HRS_PTR_RESET;
                next_state.rsp.faultReset = 1'b1;
            end
        end
        else if (coreReq.pop)
        begin
            // Read the top, then drop the index
            next_state.rsp.popPc    = topValue;
            next_state.rsp.popValid = 1'b1;
            next_state.ptr          = ptrDown;
            next_state.lastOp       = HRS_OP_POP;
            if (faultEvt[`HRS_BIT_UNF] && state.faultResetEnable)
            begin
                next_state.ptr = `HRS_PTR_RESET;
                next_state.rsp.faultReset = 1'b1;
            end
        end
        else if (regWrHit)
        begin
            // Software may rewrite index and entries only when idle
            case (regReq.addr)
                `HRS_OFS_TOP_LOW:
                begin
                    memWrData[`HRS_DATA_W-1:0] = regReq.wrData;
                    memWrLow = 1'b1;
                end
                `HRS_OFS_TOP_HIGH:
                begin
                    memWrData[`HRS_PC_W-1:`HRS_DATA_W] =
                        regReq.wrData[`HRS_HIGH_W-1:0];
                    memWrHigh = 1'b1;
                end
                `HRS_OFS_INDEX:
                begin
                    next_state.ptr =
                        regReq.wrData[`HRS_PTR_W-1:0];
                end
                `HRS_OFS_CONFIG:
                begin
                    next_state.faultResetEnable =
                        regReq.wrData[`HRS_BIT_FRE];
                end
                default:
                begin
                    next_state.ptr = state.ptr;
                end
            endcase
        end

        // Read data stand one cycle after the strobe
        if (regReq.rd)
        begin
            case (regReq.addr)
                `HRS_OFS_TOP_LOW:
                begin
                    next_state.rdData =
                        topValue[`HRS_DATA_W-1:0];
                end
                `HRS_OFS_TOP_HIGH:
                begin
                    next_state.rdData = {1'b0,
                        topValue[`HRS_PC_W-1:`HRS_DATA_W]};
                end
                `HRS_OFS_INDEX:
                begin
                    next_state.rdData = {3'h0, state.ptr};
                end
                `HRS_OFS_CONFIG:
                begin
                    next_state.rdData = {7'h00, state.faultResetEnable};
                end
                `HRS_OFS_STATUS:
                begin
                    next_state.rdData = {6'h00, irqStatus};
                end
                `HRS_OFS_INT_ENABLE:
                begin
                    next_state.rdData = {6'h00, irqEnable};
                end
                default:
                begin
                    // Clear register and unmapped offsets read zero
                    next_state.rdData = '0;
                end
            endcase
        end
    end

    // Reset empties the stack and turns fault reset off
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state <= '0;
            state.ptr <= `HRS_PTR_RESET;
            state.faultResetEnable <= `HRS_CFG_RESET;
            state.lastOp <= HRS_OP_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign coreRsp   = state.rsp;
    assign regRdData = state.rdData;

    // Checks on the behaviour of the stack
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_plain_push;
        coreReq.push && !faultEvt[`HRS_BIT_OVF];
    endsequence

    sequence s_plain_pop;
        !coreReq.push && coreReq.pop && !faultEvt[`HRS_BIT_UNF];
    endsequence

    a_push_ptr_up: assert property (
        s_plain_push |=> state.ptr == $past(state.ptr) + 5'h01)
        else $error("push did not advance the index by one");

    a_pop_ptr_down: assert property (
        s_plain_pop |=> state.ptr == $past(state.ptr) - 5'h01)
        else $error("pop did not lower the index by one");

    a_reset_empty: assert property (
        $fell(reset) |-> state.ptr == 5'h1F)
        else $error("stack not empty after reset");

    a_ovf_flag_set: assert property (
        (coreReq.push && state.ptr == 5'h0F) |=> irqStatus[0])
        else $error("overflow flag missing");

    a_unf_flag_set: assert property (
        (!coreReq.push && coreReq.pop && state.ptr == 5'h1F)
        |=> irqStatus[1])
        else $error("underflow flag missing");

    a_fault_reset_out: assert property (
        (|faultEvt && state.faultResetEnable)
        |=> coreRsp.faultReset && state.ptr == 5'h1F ##1 !coreRsp.faultReset)
        else $error("fault reset pulse wrong");

    a_wrap_no_reset: assert property (
        (|faultEvt && !state.faultResetEnable) |=> !coreRsp.faultReset)
        else $error("fault reset raised while wrapping");

    a_empty_top_zero: assert property (
        (regReq.rd && regReq.addr == 3'h0 && emptyZero)
        |=> regRdData == 8'h00)
        else $error("empty stack top did not read zero");

    a_push_pop_data: assert property (
        (s_plain_pop and $past(coreReq.push) and
         !$past(faultEvt[`HRS_BIT_OVF]))
        |=> coreRsp.popValid && coreRsp.popPc == $past(coreReq.pc, 2))
        else $error("pop did not return the last pushed value");

    a_index_write: assert property (
        (regWrHit && regReq.addr == 3'h2)
        |=> state.ptr == $past(regReq.wrData[4:0]))
        else $error("index write not taken");

endmodule : hrs_return_stack

// >>> hrs_core_model.sv
// Core sequencer stand-in that issues push and pop pulses to the stack
`timescale 1ns/1ps

module hrs_core_model
    import hrs_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     reset,
    input  wire hrs_op_e  cmdOp,
    input  wire hrs_pc_t  cmdPc,
    output hrs_core_req_s coreReq
);
    initial coreReq = '0;

    // One request a cycle; the PC lines toggle between pushes so a stale
    // value is never mistaken for a pushed one
    always @(posedge ref_clk)
    begin
        coreReq.push <= !reset && cmdOp == HRS_OP_PUSH;
        coreReq.pop  <= !reset && cmdOp == HRS_OP_POP;
        coreReq.pc   <= (cmdOp == HRS_OP_PUSH) ? cmdPc : ~coreReq.pc;
    end
endmodule : hrs_core_model

// >>> hardware_return_stack_tb.sv
// Self-checking bench for the return stack with a reference model
`timescale 1ns/1ps
`include "hrs_params.svh"

module hardware_return_stack_tb
    import hrs_pkg::*;
;
    logic          ref_clk = 1'b0;
    logic          reset = 1'b1;
    hrs_op_e       cmdOp = HRS_OP_IDLE;
    hrs_pc_t       cmdPc = '0;
    hrs_reg_req_s  regReq = '0;
    hrs_core_req_s coreReq;
    hrs_core_rsp_s coreRsp;
    hrs_byte_t     regRdData;
    logic          stackIrq;
    logic          rdSeen = 1'b0;
    hrs_pc_t       refMem [`HRS_DEPTH];
    hrs_ptr_t      refPtr;
    logic          refCfg;
    hrs_evt_t      refStatus, refEn;
    logic [15:0]   popQ [$];
    hrs_byte_t     rdQ [$];
    logic          faultQ [$];
    int            seed = 32'h9efa;
    int            cycles = 0;
    int            miscompares = 0;
    int            totalChecks = 0;

    always #25 ref_clk = ~ref_clk;

    hrs_core_model core (.ref_clk(ref_clk), .reset(reset), .cmdOp(cmdOp),
                         .cmdPc(cmdPc), .coreReq(coreReq));
    hrs_return_stack uut (.ref_clk(ref_clk), .reset(reset),
                          .coreReq(coreReq), .coreRsp(coreRsp),
                          .regReq(regReq), .regRdData(regRdData),
                          .stackIrq(stackIrq));

    task automatic finishTest;
        $display("checks %0d, mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finishTest

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Reference stack; skip bit 15 marks a pop whose value is left open
    function automatic void refStep(input hrs_op_e op, input hrs_pc_t pc);
        if (op == HRS_OP_PUSH && refPtr == `HRS_PTR_FULL)
            refStatus[`HRS_BIT_OVF] = 1'b1;
        if (op == HRS_OP_POP && refPtr == `HRS_PTR_RESET)
            refStatus[`HRS_BIT_UNF] = 1'b1;
        if (op == HRS_OP_PUSH && refPtr == `HRS_PTR_FULL && refCfg)
        begin
            faultQ.push_back(1'b1);
            refPtr = `HRS_PTR_RESET;
        end
        else if (op == HRS_OP_PUSH)
        begin
            refPtr = refPtr + `HRS_PTR_ONE;
            refMem[refPtr[3:0]] = pc;
        end
        else if (refPtr == `HRS_PTR_RESET && refCfg)
        begin
            faultQ.push_back(1'b1);
            popQ.push_back(16'h0000);
        end
        else
        begin
            if (refPtr == `HRS_PTR_RESET)
                popQ.push_back(16'h8000);
            else
                popQ.push_back({1'b0, refMem[refPtr[3:0]]});
            refPtr = refPtr - `HRS_PTR_ONE;
        end
    endfunction : refStep

    task automatic coreOps(input hrs_op_e op, input int n);
        hrs_pc_t pc;
        for (int i = 0; i < n; i++)
        begin
            pc = hrs_pc_t'($random(seed));
            @(posedge ref_clk);
            cmdOp <= op;
            cmdPc <= pc;
            refStep(op, pc);
        end
        @(posedge ref_clk);
        cmdOp <= HRS_OP_IDLE;
    endtask : coreOps

    // Push and pop in adjacent cycles, so a pop meets a fresh entry
    task automatic pushPop(input int n);
        hrs_pc_t pc;
        for (int i = 0; i < n; i++)
        begin
            pc = hrs_pc_t'($random(seed));
            @(posedge ref_clk);
            cmdOp <= HRS_OP_PUSH;
            cmdPc <= pc;
            refStep(HRS_OP_PUSH, pc);
            @(posedge ref_clk);
            cmdOp <= HRS_OP_POP;
            refStep(HRS_OP_POP, pc);
        end
        @(posedge ref_clk);
        cmdOp <= HRS_OP_IDLE;
    endtask : pushPop

    // With busy set a push lands in the same cycle and a write to the stack side is lost
    task automatic regWrite(input logic [2:0] a, input hrs_byte_t d,
                            input logic busy);
        hrs_pc_t pc;
        pc = hrs_pc_t'($random(seed));
        if (busy)
        begin
            @(posedge ref_clk);
            cmdOp <= HRS_OP_PUSH;
            cmdPc <= pc;
            refStep(HRS_OP_PUSH, pc);
        end
        @(posedge ref_clk);
        cmdOp <= HRS_OP_IDLE;
        regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        if (!busy)
            case (a)
                `HRS_OFS_INDEX:      refPtr = d[4:0];
                `HRS_OFS_TOP_LOW:    refMem[refPtr[3:0]][7:0] = d;
                `HRS_OFS_TOP_HIGH:   refMem[refPtr[3:0]][14:8] = d[6:0];
                `HRS_OFS_CONFIG:     refCfg = d[`HRS_BIT_FRE];
                `HRS_OFS_INT_CLEAR:  refStatus = refStatus & ~d[1:0];
                `HRS_OFS_INT_ENABLE: refEn = d[1:0];
                default:             ;
            endcase
        @(posedge ref_clk);
        regReq.wr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [2:0] a, input hrs_byte_t exp);
        @(posedge ref_clk);
        regReq <= '{addr: a, wrData: hrs_byte_t'($random(seed)), wr: 1'b0,
                    rd: 1'b1};
        rdQ.push_back(exp);
        @(posedge ref_clk);
        regReq.rd <= 1'b0;
    endtask : regRead

    task automatic checkIrq;
        @(posedge ref_clk);
        #1;
        check(16'(stackIrq), 16'(|(refStatus & refEn)));
    endtask : checkIrq

    // Waits out any pending fault pulse before the reset lands
    task automatic doReset;
        // At start-up reset already stands, so the three-edge wait is skipped
        if (!reset)
            repeat (3) @(posedge ref_clk);
        reset <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        refPtr = `HRS_PTR_RESET;
        refCfg = 1'b0;
        refStatus = '0;
        refEn = '0;
        for (int i = 0; i < `HRS_DEPTH; i++)
            refMem[i] = '0;
    endtask : doReset

    // Output watcher: each result takes the oldest note of its kind
    always @(posedge ref_clk)
    begin
        rdSeen <= regReq.rd;
        cycles <= cycles + 1;
        // Outputs are unknown until the first reset edge has been taken
        if (cycles != 0)
        begin
            if (rdSeen && rdQ.size() != 0)
                check(16'(regRdData), 16'(rdQ.pop_front()));
            else
                check(16'(regRdData), 16'h0000);
            if (coreRsp.popValid !== 1'b0 && popQ.size() == 0)
                check(16'h0001, 16'h0000);
            else if (coreRsp.popValid !== 1'b0 && !popQ[0][15])
                check({1'b0, coreRsp.popPc}, popQ.pop_front());
            else if (coreRsp.popValid !== 1'b0)
                void'(popQ.pop_front());
            if (coreRsp.faultReset !== 1'b0)
            begin
                check(16'(faultQ.size() != 0), 16'h0001);
                if (faultQ.size() != 0)
                    void'(faultQ.pop_front());
            end
        end
        if (cycles == 4000)
        begin
            miscompares++;
            finishTest();
        end
    end

    // Main sequence: register space, stacking, wrap, flags, fault mode
    initial
    begin
        doReset();
        regRead(`HRS_OFS_INDEX, 8'h1F);
        regRead(`HRS_OFS_CONFIG, 8'h00);
        regRead(`HRS_OFS_STATUS, 8'h00);
        regRead(3'h7, 8'h00);
        regWrite(`HRS_OFS_INT_ENABLE, 8'h03, 1'b0);
        regRead(`HRS_OFS_INT_ENABLE, 8'h03);
        coreOps(HRS_OP_PUSH, 3);
        regRead(`HRS_OFS_INDEX, 8'h02);
        coreOps(HRS_OP_POP, 3);
        regRead(`HRS_OFS_INDEX, 8'h1F);
        pushPop(2);
        regWrite(`HRS_OFS_INDEX, 8'h05, 1'b0);
        regWrite(`HRS_OFS_TOP_LOW, 8'hA5, 1'b0);
        regWrite(`HRS_OFS_TOP_HIGH, 8'hFF, 1'b0);
        regRead(`HRS_OFS_TOP_LOW, 8'hA5);
        regRead(`HRS_OFS_TOP_HIGH, 8'h7F);
        coreOps(HRS_OP_POP, 1);
        regWrite(`HRS_OFS_INDEX, 8'h0A, 1'b1);
        regRead(`HRS_OFS_INDEX, {3'h0, refPtr});
        regWrite(`HRS_OFS_INDEX, 8'h1F, 1'b0);
        coreOps(HRS_OP_PUSH, 18);
        checkIrq();
        regRead(`HRS_OFS_STATUS, 8'h01);
        regRead(`HRS_OFS_INDEX, 8'h11);
        regWrite(`HRS_OFS_INDEX, 8'h00, 1'b0);
        regRead(`HRS_OFS_TOP_LOW, refMem[0][7:0]);
        coreOps(HRS_OP_POP, 1);
        regWrite(`HRS_OFS_INT_CLEAR, 8'h01, 1'b0);
        checkIrq();
        regWrite(`HRS_OFS_STATUS, 8'hFF, 1'b0);
        regRead(`HRS_OFS_STATUS, 8'h00);
        coreOps(HRS_OP_POP, 1);
        checkIrq();
        regWrite(`HRS_OFS_INT_ENABLE, 8'h01, 1'b0);
        checkIrq();
        regRead(`HRS_OFS_STATUS, 8'h02);
        doReset();
        regWrite(`HRS_OFS_CONFIG, 8'h01, 1'b0);
        regRead(`HRS_OFS_TOP_LOW, 8'h00);
        regRead(`HRS_OFS_TOP_HIGH, 8'h00);
        regWrite(`HRS_OFS_INT_ENABLE, 8'h03, 1'b0);
        coreOps(HRS_OP_POP, 1);
        checkIrq();
        doReset();
        regWrite(`HRS_OFS_CONFIG, 8'h01, 1'b0);
        coreOps(HRS_OP_PUSH, 17);
        regRead(`HRS_OFS_INDEX, 8'h1F);
        regRead(`HRS_OFS_STATUS, 8'h01);
        doReset();
        regRead(`HRS_OFS_INDEX, 8'h1F);
        repeat (4) @(posedge ref_clk);
        check(16'(popQ.size() + rdQ.size() + faultQ.size()),
              16'h0000);
        finishTest();
    end
endmodule : hardware_return_stack_tb
